// ==== scg_pkg.sv ====
// Shared constants and carrier types for the system clock generator
package scg_pkg;

  // ----------------------------------------------------------------
  // Field widths
  // ----------------------------------------------------------------
  localparam int MH_W = 10;
  localparam int ML_W = 2;
  localparam int RD_W = 12;
  localparam int OD_W = 6;
  localparam int MULT_W = 13;
  localparam int REF_RATIO_W = 13;
  localparam int OUT_RATIO_W = 7;
  localparam int HALF_RATIO_W = 2;
  localparam int SRC_W = 4;

  // ----------------------------------------------------------------
  // Ratio arithmetic
  // ----------------------------------------------------------------
  localparam logic [MULT_W-1:0] MULT_OFFSET = 13'h0004;
  localparam logic [REF_RATIO_W-1:0] REF_RATIO_OFFSET = 13'h0004;
  localparam logic [OUT_RATIO_W-1:0] OUT_RATIO_OFFSET = 7'h04;
  localparam logic [HALF_RATIO_W-1:0] FIXED_HALF_RATIO = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_HZ = 20_000_000;
  localparam int LOCK_TIME_US = 4000;
  localparam int LOCK_CYCLES =
    (LOCK_TIME_US * (CLK_FREQ_HZ / 1_000_000));

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic IDLE_HOLD_RST = 1'b1;
  localparam logic PLL_SEL_RST = 1'b0;
  localparam logic POWER_DOWN_RST = 1'b0;

  // ----------------------------------------------------------------
  // Debug pin source codes
  // ----------------------------------------------------------------
  localparam logic [SRC_W-1:0] SRC_FORCE_HIGH = 4'h1;
  localparam logic [SRC_W-1:0] SRC_FORCE_LOW_A = 4'h3;
  localparam logic [SRC_W-1:0] SRC_FORCE_LOW_B = 4'h5;
  localparam logic [SRC_W-1:0] SRC_USB_A = 4'h7;
  localparam logic [SRC_W-1:0] SRC_SAR = 4'h9;
  localparam logic [SRC_W-1:0] SRC_SYSTEM = 4'hB;
  localparam logic [SRC_W-1:0] SRC_RESERVED = 4'hD;
  localparam logic [SRC_W-1:0] SRC_USB_B = 4'hF;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [MH_W-1:0] multiplier_high_field;
    logic [ML_W-1:0] multiplier_low_field;
    logic [RD_W-1:0] ref_divider_ratio;
    logic [OD_W-1:0] output_divide_value;
    logic ref_divider_bypass;
    logic out_divider_enable;
    logic prog_out_divider_bypass;
  } scg_cfg_t;

  typedef struct packed {
    logic rtc_osc_clock;
    logic external_ref_clock_input;
    logic pll_output_clock;
    logic usb_pll_clock;
    logic sar_clock;
  } scg_clk_in_t;

  typedef enum logic [2:0] {
    ST_BYP = 3'h0,
    ST_BYP_OFF = 3'h1,
    ST_PLL_ON = 3'h2,
    ST_PLL = 3'h3,
    ST_PLL_OFF = 3'h4,
    ST_BYP_ON = 3'h5
  } scg_sw_state_t;

endpackage

// ==== scg_sync.sv ====
// Two-flop synchroniser for asynchronous levels
`timescale 1ns/1ps
module scg_sync
  import scg_pkg::*;
#(
  parameter int W = 1
)
(
  input wire logic sys_clk, // System clock
  input wire logic reset, // Synchronous reset, high
  input wire logic clk_en, // Freezes state while low
  input wire logic [W-1:0] async_in, // Asynchronous levels
  output logic [W-1:0] sync_out // Synchronised levels
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb
  begin
    meta_d = meta_q;
    sync_d = sync_q;
    if (clk_en)
    begin
      meta_d = async_in;
      sync_d = meta_q;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      // Keeps sampling in reset so a static level is settled at release
      meta_q <= async_in;
      sync_q <= meta_q;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

// ==== scg_divider.sv ====
// Programmable edge-counting divider for a sampled clock level
`timescale 1ns/1ps
module scg_divider
  import scg_pkg::*;
#(
  parameter int W = 13
)
(
  input wire logic sys_clk, // System clock
  input wire logic reset, // Synchronous reset, high
  input wire logic clk_en, // Freezes state while low
  input wire logic clk_in, // Sampled input clock level
  input wire logic [W-1:0] ratio, // Division ratio, at least 2
  output logic clk_out // Divided clock level
);

  logic prev_q;
  logic prev_d;
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic out_q;
  logic out_d;

  // Output high for the first half of each ratio-long period
  always_comb
  begin
    prev_d = prev_q;
    cnt_d = cnt_q;
    out_d = out_q;
    if (clk_en)
    begin
      prev_d = clk_in;
      if (clk_in && !prev_q)
      begin
        if (cnt_q >= ratio - W'(1))
          cnt_d = '0;
        else
          cnt_d = cnt_q + W'(1);
        out_d = (cnt_d < (ratio >> 1));
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      prev_q <= 1'b0;
      cnt_q <= '0;
      out_q <= 1'b0;
    end
    else
    begin
      prev_q <= prev_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign clk_out = out_q;

endmodule

// ==== scg_clock_gen.sv ====
// System clock generator control: dividers, mode switch, debug pin
// Functional notes
// - PLL multiplies its input by a programmable factor, 4 to 4099.
// - Reference divider divides input by 4 to 4099, bypassable.
// - Output divider divides PLL output by 4 to 67, bypassable.
// - Fixed halving stage after output divider or PLL, bypassable.
// - Multiplier is high<<2 plus low plus 4; dividers are value plus 4.
// - Bypass and enable bits route clocks through the divider stages.
// - Select zero gives bypass mode; one gives PLL and dividers.
// - Bypass source: oscillator when strap is zero, external pin else.
// - Mode switching in either direction makes no glitch.
// - Power-down bit stops the PLL; bypass must come first.
// - Clearing power-down starts a 4 ms lock; stay in bypass.
// - Bypass mode alone never powers the PLL down.
// - Even codes give PLL clock; 1 high; 3 and 5 low.
// - 7 and 15 USB, 9 SAR, 11 system clock; 13 reserved.
// - Debug pin source changes are not glitch protected.
// - Pin-off bit releases the debug pin to high impedance.
// - Reset sets idle hold and clears the PLL select.
`timescale 1ns/1ps
module scg_clock_gen
  import scg_pkg::*;
#(
  parameter int LOCK_CYCLES_P = LOCK_CYCLES
)
(
  input wire logic sys_clk, // System clock, 20 MHz
  input wire logic reset, // Synchronous reset, high
  input wire logic clk_en, // Freezes all state while low
  input wire scg_clk_in_t clocks_in, // Asynchronous source clocks
  input wire logic reference_source_strap, // Board strap, 1 = ext
  input wire scg_cfg_t cfg, // Multiplier and divider settings
  input wire logic system_clock_select, // 1 = PLL mode
  input wire logic pll_power_down, // 1 = PLL powered down
  input wire logic pll_standby, // 1 = hold PLL idle
  input wire logic [SRC_W-1:0] clock_pin_source_sel, // Debug source
  input wire logic clock_pin_off, // 1 = debug pin released
  output logic dsp_system_clock, // Generated system clock
  output logic pll_input_clock, // Reference after divider
  output logic [MULT_W-1:0] pll_multiplier, // Factor to the PLL
  output logic pll_power_down_out, // Power-down to the PLL
  output logic loop_idle_hold, // Idle hold to the PLL
  output logic pll_locked, // Lock wait elapsed
  output logic pll_mode_active, // System clock runs from PLL
  output logic debug_clock_pin_o, // Debug pin level
  output logic debug_clock_pin_oe // Debug pin driven when high
);

  // ----------------------------------------------------------------
  // Synchronisers and strap capture
  // ----------------------------------------------------------------
  scg_clk_in_t clk_s;
  logic strap_s;
  logic strap_q;
  logic strap_d;
  logic strap_ok_q;
  logic strap_ok_d;

  scg_sync #(.W($bits(scg_clk_in_t))) u_clk_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .clk_en(clk_en),
    .async_in(clocks_in),
    .sync_out(clk_s)
  );

  scg_sync #(.W(1)) u_strap_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .clk_en(clk_en),
    .async_in(reference_source_strap),
    .sync_out(strap_s)
  );

  // Strap is static, so one capture after release is enough
  always_comb
  begin
    strap_d = strap_q;
    strap_ok_d = strap_ok_q;
    if (clk_en && !strap_ok_q)
    begin
      strap_d = strap_s;
      strap_ok_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      strap_q <= 1'b0;
      strap_ok_q <= 1'b0;
    end
    else
    begin
      strap_q <= strap_d;
      strap_ok_q <= strap_ok_d;
    end
  end

  logic ref_clk;
  assign ref_clk = strap_q ? clk_s.external_ref_clock_input
                           : clk_s.rtc_osc_clock;

  // ----------------------------------------------------------------
  // Divider chain
  // ----------------------------------------------------------------
  logic [REF_RATIO_W-1:0] ref_ratio;
  logic [OUT_RATIO_W-1:0] out_ratio;
  logic ref_div_clk;
  logic od_clk;
  logic half_in;
  logic half_clk;
  logic pll_path_clk;

  assign ref_ratio = {1'b0, cfg.ref_divider_ratio} + REF_RATIO_OFFSET;
  assign out_ratio = {1'b0, cfg.output_divide_value} + OUT_RATIO_OFFSET;

  scg_divider #(.W(REF_RATIO_W)) u_ref_div (
    .sys_clk(sys_clk),
    .reset(reset),
    .clk_en(clk_en),
    .clk_in(ref_clk),
    .ratio(ref_ratio),
    .clk_out(ref_div_clk)
  );

  scg_divider #(.W(OUT_RATIO_W)) u_out_div (
    .sys_clk(sys_clk),
    .reset(reset),
    .clk_en(clk_en),
    .clk_in(clk_s.pll_output_clock),
    .ratio(out_ratio),
    .clk_out(od_clk)
  );

  assign half_in = cfg.prog_out_divider_bypass ? clk_s.pll_output_clock
                                               : od_clk;

  scg_divider #(.W(HALF_RATIO_W)) u_half_div (
    .sys_clk(sys_clk),
    .reset(reset),
    .clk_en(clk_en),
    .clk_in(half_in),
    .ratio(FIXED_HALF_RATIO),
    .clk_out(half_clk)
  );

  assign pll_path_clk = cfg.out_divider_enable ? half_clk
                                               : clk_s.pll_output_clock;

  // ----------------------------------------------------------------
  // PLL control and lock wait
  // ----------------------------------------------------------------
  localparam int LCW = $clog2(LOCK_CYCLES_P + 1);
  logic [LCW-1:0] lock_cnt_q;
  logic [LCW-1:0] lock_cnt_d;
  logic locked_q;
  logic locked_d;
  logic pd_q;
  logic pd_d;
  logic idle_q;
  logic idle_d;
  logic pin_in_q;
  logic pin_in_d;
  logic [MULT_W-1:0] mult_q;
  logic [MULT_W-1:0] mult_d;

  always_comb
  begin
    lock_cnt_d = lock_cnt_q;
    locked_d = locked_q;
    pd_d = pd_q;
    idle_d = idle_q;
    pin_in_d = pin_in_q;
    mult_d = mult_q;
    if (clk_en)
    begin
      pd_d = pll_power_down;
      idle_d = pll_standby;
      pin_in_d = cfg.ref_divider_bypass ? ref_clk : ref_div_clk;
      mult_d = {1'b0, cfg.multiplier_high_field, cfg.multiplier_low_field}
               + MULT_OFFSET;
      // Restart the wait whenever the PLL is stopped
      if (pd_q || idle_q)
        lock_cnt_d = '0;
      else if (lock_cnt_q != LCW'(LOCK_CYCLES_P))
        lock_cnt_d = lock_cnt_q + LCW'(1);
      locked_d = (lock_cnt_d == LCW'(LOCK_CYCLES_P));
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      lock_cnt_q <= '0;
      locked_q <= 1'b0;
      pd_q <= POWER_DOWN_RST;
      idle_q <= IDLE_HOLD_RST;
      pin_in_q <= 1'b0;
      mult_q <= MULT_OFFSET;
    end
    else
    begin
      lock_cnt_q <= lock_cnt_d;
      locked_q <= locked_d;
      pd_q <= pd_d;
      idle_q <= idle_d;
      pin_in_q <= pin_in_d;
      mult_q <= mult_d;
    end
  end

  // ----------------------------------------------------------------
  // Glitch-free mode switch
  // ----------------------------------------------------------------
  // Each enable only moves while its own clock is low, so neither
  // source can be cut mid-pulse.
  scg_sw_state_t state_q;
  scg_sw_state_t state_d;
  logic sel_q;
  logic sel_d;
  logic sys_q;
  logic sys_d;
  logic mode_q;
  logic mode_d;
  logic byp_en;
  logic pll_en;

  assign byp_en = (state_q == ST_BYP) || (state_q == ST_BYP_OFF);
  assign pll_en = (state_q == ST_PLL) || (state_q == ST_PLL_OFF);

  always_comb
  begin
    state_d = state_q;
    sel_d = sel_q;
    sys_d = sys_q;
    if (clk_en)
    begin
      sel_d = system_clock_select;
      sys_d = (byp_en & ref_clk) | (pll_en & pll_path_clk);
      case (state_q)
        ST_BYP:
          if (sel_q)
            state_d = ST_BYP_OFF;
        ST_BYP_OFF:
          if (!sel_q)
            state_d = ST_BYP;
          else if (!ref_clk)
            state_d = ST_PLL_ON;
        ST_PLL_ON:
          if (!clk_s.pll_output_clock && !pll_path_clk)
            state_d = ST_PLL;
        ST_PLL:
          if (!sel_q)
            state_d = ST_PLL_OFF;
        ST_PLL_OFF:
          if (!pll_path_clk)
            state_d = ST_BYP_ON;
        ST_BYP_ON:
          if (!ref_clk)
            state_d = ST_BYP;
        default:
          state_d = ST_BYP;
      endcase
    end
    // Registered copy of the PLL gate so the output comes from a flop
    mode_d = (state_d == ST_PLL) || (state_d == ST_PLL_OFF);
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state_q <= ST_BYP;
      sel_q <= PLL_SEL_RST;
      sys_q <= 1'b0;
      mode_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      sel_q <= sel_d;
      sys_q <= sys_d;
      mode_q <= mode_d;
    end
  end

  // ----------------------------------------------------------------
  // Debug clock pin
  // ----------------------------------------------------------------
  // No glitch protection when the source code changes mid-pulse
  function automatic logic pin_source(input logic [SRC_W-1:0] code,
                                      input logic pll,
                                      input logic usb,
                                      input logic sar,
                                      input logic sys);
    logic val;
    val = 1'b0;
    if (!code[0])
      val = pll;
    else if (code == SRC_FORCE_HIGH)
      val = 1'b1;
    else if (code == SRC_FORCE_LOW_A || code == SRC_FORCE_LOW_B)
      val = 1'b0;
    else if (code == SRC_USB_A || code == SRC_USB_B)
      val = usb;
    else if (code == SRC_SAR)
      val = sar;
    else if (code == SRC_SYSTEM)
      val = sys;
    else
      val = 1'b0;
    return val;
  endfunction

  logic dbg_q;
  logic dbg_d;
  logic dbg_oe_q;
  logic dbg_oe_d;

  always_comb
  begin
    dbg_d = dbg_q;
    dbg_oe_d = dbg_oe_q;
    if (clk_en)
    begin
      dbg_d = pin_source(clock_pin_source_sel, clk_s.pll_output_clock,
                         clk_s.usb_pll_clock, clk_s.sar_clock,
                         sys_q);
      dbg_oe_d = !clock_pin_off;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      dbg_q <= 1'b0;
      dbg_oe_q <= 1'b0;
    end
    else
    begin
      dbg_q <= dbg_d;
      dbg_oe_q <= dbg_oe_d;
    end
  end

  assign dsp_system_clock = sys_q;
  assign pll_input_clock = pin_in_q;
  assign pll_multiplier = mult_q;
  assign pll_power_down_out = pd_q;
  assign loop_idle_hold = idle_q;
  assign pll_locked = locked_q;
  assign pll_mode_active = mode_q;
  assign debug_clock_pin_o = dbg_q;
  assign debug_clock_pin_oe = dbg_oe_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_pin_release: assert property (clk_en && clock_pin_off |=>
    !debug_clock_pin_oe) else $error("debug pin driven while off");
  a_pin_force_high: assert property (
    clk_en && clock_pin_source_sel == SRC_FORCE_HIGH |=> debug_clock_pin_o)
    else $error("debug pin not high for code 1");
  a_pin_force_low: assert property (clk_en &&
    (clock_pin_source_sel == SRC_FORCE_LOW_A ||
     clock_pin_source_sel == SRC_FORCE_LOW_B) |=> !debug_clock_pin_o)
    else $error("debug pin not low for codes 3 or 5");
  a_pin_dsp_system_clock: assert property (
    clk_en && clock_pin_source_sel == SRC_SYSTEM |=>
    debug_clock_pin_o == $past(dsp_system_clock))
    else $error("debug pin does not follow system clock");
  a_bypass_source: assert property (
    clk_en && state_q == ST_BYP |=> dsp_system_clock == $past(ref_clk))
    else $error("bypass clock does not follow reference");
  a_mult_value: assert property (clk_en |=>
    pll_multiplier == ({1'b0, $past(cfg.multiplier_high_field),
                        $past(cfg.multiplier_low_field)} + 13'h0004))
    else $error("multiplier value wrong");
  a_bypass_no_pd: assert property (
    clk_en && !pll_power_down && !sel_q |=> !pll_power_down_out)
    else $error("bypass powered the PLL down");
  a_switch_clean: assert property (
    $fell(byp_en) |-> !$past(ref_clk))
    else $error("bypass clock cut while high");
  a_pll_clean: assert property (
    $fell(pll_en) |-> !$past(pll_path_clk))
    else $error("PLL clock cut while high");
  a_lock_wait: assert property (
    $fell(pll_power_down_out) |-> !pll_locked [*8])
    else $error("lock reported too early");
  a_route_raw: assert property (
    clk_en && pll_en && !cfg.out_divider_enable |=>
    dsp_system_clock == $past(clk_s.pll_output_clock))
    else $error("output stages not skipped");
  a_reset_state: assert property (disable iff (1'b0)
    reset |=> loop_idle_hold && !pll_mode_active)
    else $error("reset defaults wrong");

  c_enter_pll: cover property (state_q == ST_PLL_ON ##1 state_q == ST_PLL);
  c_back_bypass: cover property (state_q == ST_BYP_ON ##1 state_q == ST_BYP);
  c_locked: cover property ($rose(pll_locked));
  c_pin_off: cover property ($fell(debug_clock_pin_oe));

endmodule

// ==== tb_top.sv ====
// Self-checking testbench for the system clock generator control block
`timescale 1ns/1ps
module tb_top;
  import scg_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int LOCK = 20;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  scg_clk_in_t clk_i = '0;
  logic strap = 1'b1;
  scg_cfg_t cfg = '0;
  logic sel = 1'b0;
  logic pd = 1'b1;
  logic stby = 1'b1;
  logic [SRC_W-1:0] src = 4'hB;
  logic pin_off = 1'b1;
  logic dsp_clk, pin_clk, pd_out, idle, locked, mode, pin_o, pin_oe;
  logic [MULT_W-1:0] mult;
  logic run_clks = 1'b0;
  logic watch = 1'b0;
  logic last_clk = 1'b0;
  int run_len = 0;
  int min_run = 0;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int ph = 0;
  int en_t[5] = '{0, 1, 1, 1, 1};
  int ob_t[5] = '{0, 1, 0, 0, 0};
  int od_t[5] = '{0, 0, 0, 1, 63};
  int rb_t[5] = '{1, 0, 0, 1, 0};
  int rd_t[5] = '{0, 0, 1, 0, 2};

  scg_clock_gen #(.LOCK_CYCLES_P(LOCK)) dut (.sys_clk(sys_clk),
    .reset(reset), .clk_en(clk_en), .clocks_in(clk_i),
    .reference_source_strap(strap), .cfg(cfg),
    .system_clock_select(sel), .pll_power_down(pd), .pll_standby(stby),
    .clock_pin_source_sel(src), .clock_pin_off(pin_off),
    .dsp_system_clock(dsp_clk), .pll_input_clock(pin_clk),
    .pll_multiplier(mult), .pll_power_down_out(pd_out),
    .loop_idle_hold(idle), .pll_locked(locked), .pll_mode_active(mode),
    .debug_clock_pin_o(pin_o), .debug_clock_pin_oe(pin_oe));

  always #25 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Source clocks and monitors
  // ----------------------------------------------------------------
  // Periods of 6, 8 and 10 cycles keep every source well under 10 MHz
  always @(negedge sys_clk)
    if (run_clks)
    begin
      ph <= ph + 1;
      clk_i.pll_output_clock <= (ph % 6) < 3;
      clk_i.external_ref_clock_input <= (ph % 8) < 4;
      clk_i.rtc_osc_clock <= (ph % 10) < 5;
    end

  // Shortest high or low run of the system clock while watched
  always @(negedge sys_clk)
    if (watch)
    begin
      if (dsp_clk === last_clk)
        run_len++;
      else
      begin
        if (run_len < min_run)
          min_run = run_len;
        run_len = 1;
      end
      last_clk = dsp_clk;
    end

  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_errors++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic close_out;
    if (n_errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %s exp %b got %b", nm, e, g);
    end
  endtask

  task automatic chk_mult(input logic [MULT_W-1:0] e);
    tests_run++;
    if (mult !== e)
    begin
      n_errors++;
      $display("MISMATCH pll_multiplier exp %h got %h", e, mult);
    end
  endtask

  task automatic chk_per(input string nm, input int e, input int g);
    tests_run++;
    if (g != e)
    begin
      n_errors++;
      $display("MISMATCH %s exp %0d got %0d", nm, e, g);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic do_reset(input logic s);
    strap = s;
    reset = 1'b1;
    cycles(20);
    reset = 1'b0;
  endtask

  task automatic wait_mode(input logic v);
    int n;
    n = 0;
    while (mode !== v && n < 1000)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk_bit("pll_mode_active", v, mode);
  endtask

  function automatic logic sig(input logic w);
    return w ? pin_clk : dsp_clk;
  endfunction

  // Cycles between two rising edges of the system or PLL input clock
  task automatic period(input logic w, output int p);
    int n;
    int r0;
    n = 0;
    r0 = 0;
    for (int k = 0; k < 2; k++)
    begin
      while (sig(w) !== 1'b0 && n < 2000)
      begin
        @(negedge sys_clk);
        n++;
      end
      while (sig(w) !== 1'b1 && n < 2000)
      begin
        @(negedge sys_clk);
        n++;
      end
      if (k == 0)
        r0 = n;
    end
    p = n - r0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_vals;
    chk_bit("loop_idle_hold", 1'b1, idle);
    chk_bit("pll_mode_active", 1'b0, mode);
    chk_bit("debug_clock_pin_oe", 1'b0, pin_oe);
    chk_mult(13'h0004);
  endtask

  task automatic t_mult;
    logic [MH_W-1:0] mh[3] = '{10'h3FF, 10'h2ED, 10'h000};
    logic [ML_W-1:0] ml[3] = '{2'h3, 2'h0, 2'h1};
    for (int i = 0; i < 3; i++)
    begin
      cfg.multiplier_high_field = mh[i];
      cfg.multiplier_low_field = ml[i];
      cycles(3);
      chk_mult({1'b0, mh[i], 2'b00} + {11'h000, ml[i]} + 13'h0004);
    end
  endtask

  task automatic t_lock;
    int n;
    stby = 1'b0;
    cycles(3);
    chk_bit("pd_out", 1'b1, pd_out);
    chk_bit("idle_off", 1'b0, idle);
    chk_bit("locked_pd", 1'b0, locked);
    pd = 1'b0;
    n = 0;
    while (locked !== 1'b1 && n < 200)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk_bit("lock_time", 1'b1, n >= LOCK && n <= LOCK + 4);
  endtask

  task automatic t_route;
    int p;
    int e;
    run_len = 1000;
    min_run = 1000;
    last_clk = dsp_clk;
    watch = 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      sel = 1'b0;
      wait_mode(1'b0);
      cfg.out_divider_enable = en_t[i][0];
      cfg.prog_out_divider_bypass = ob_t[i][0];
      cfg.output_divide_value = 6'(od_t[i]);
      cfg.ref_divider_bypass = rb_t[i][0];
      cfg.ref_divider_ratio = 12'(rd_t[i]);
      cycles(900);
      sel = 1'b1;
      wait_mode(1'b1);
      period(1'b0, p);
      period(1'b0, p);
      e = (en_t[i] == 0) ? 6 : (ob_t[i] == 1) ? 12 : 12 * (od_t[i] + 4);
      chk_per("sys_period", e, p);
      period(1'b1, p);
      period(1'b1, p);
      e = (rb_t[i] == 1) ? 8 : 8 * (rd_t[i] + 4);
      chk_per("ref_period", e, p);
    end
    sel = 1'b0;
    wait_mode(1'b0);
    cycles(20);
    watch = 1'b0;
    chk_bit("no_glitch", 1'b1, min_run >= 3);
    chk_bit("pd_out_byp", 1'b0, pd_out);
    chk_bit("locked_byp", 1'b1, locked);
  endtask

  task automatic t_bypass;
    int p;
    period(1'b0, p);
    period(1'b0, p);
    chk_per("bypass_period", strap ? 8 : 10, p);
  endtask

  // Sources frozen so the pin level can be predicted for every code
  task automatic t_pin(input logic v);
    logic e;
    run_clks = 1'b0;
    @(negedge sys_clk);
    clk_i.pll_output_clock = v;
    clk_i.usb_pll_clock = ~v;
    clk_i.sar_clock = v;
    clk_i.rtc_osc_clock = ~v;
    clk_i.external_ref_clock_input = v;
    pin_off = 1'b0;
    for (int c = 0; c < 16; c++)
    begin
      src = c[3:0];
      cycles(6);
      if (c[0] == 1'b0)
        e = v;
      else if (c == 1)
        e = 1'b1;
      else if (c == 7 || c == 15 || c == 11)
        e = ~v;
      else if (c == 9)
        e = v;
      else
        e = 1'b0;
      chk_bit("debug_pin", e, pin_o);
      chk_bit("debug_pin_oe", 1'b1, pin_oe);
    end
    pin_off = 1'b1;
    cycles(3);
    chk_bit("debug_pin_off", 1'b0, pin_oe);
    clk_en = 1'b0;
    pin_off = 1'b0;
    cycles(3);
    chk_bit("debug_pin_frozen", 1'b0, pin_oe);
    clk_en = 1'b1;
    pin_off = 1'b1;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    do_reset(1'b1);
    t_reset_vals();
    t_mult();
    t_lock();
    run_clks = 1'b1;
    t_route();
    t_bypass();
    do_reset(1'b0);
    t_bypass();
    t_pin(1'b0);
    t_pin(1'b1);
    close_out();
  end
endmodule
